// [pkg/boot_loader_map.svh]
/*
 * Constants of the serial boot loader: register offsets, reset values,
 * block types, mode codes, response codes and address figures.
 * Assumes inclusion by bare name from the design file and the bench.
 */
`ifndef BOOT_LOADER_MAP_SVH
`define BOOT_LOADER_MAP_SVH

// Register offsets on the plain register port.
`define BL_OFF_CTRL      4'h0
`define BL_OFF_STATE     4'h1
`define BL_OFF_RESP      4'h2
`define BL_OFF_MODE      4'h3
`define BL_OFF_BAUD_LO   4'h4
`define BL_OFF_BAUD_HI   4'h5
`define BL_CTRL_RESET    8'h01
`define BL_CTRL_EN_BIT   0
`define BL_CTRL_VAR_BIT  1

// Block types.
`define BL_BLK_HEADER    8'h00
`define BL_BLK_DATA      8'h01
`define BL_BLK_END       8'h02

// Mode codes.
`define BL_MODE_XLOAD    8'h00
`define BL_MODE_XEXEC    8'h01
`define BL_MODE_FPROG    8'h02
`define BL_MODE_UEXEC    8'h03
`define BL_MODE_ERASE    8'h04
`define BL_MODE_PROT     8'h06
`define BL_MODE_LXLOAD   8'h08
`define BL_MODE_LXEXEC   8'h09
`define BL_MODE_DEBUG    8'h0F

// Responses and synchronization bytes.
`define BL_RSP_OK        8'h55
`define BL_RSP_TYPE      8'hFF
`define BL_RSP_CSUM      8'hFE
`define BL_RSP_PROT      8'hFD
`define BL_SYNC_BYTE     8'h80

// Lengths and addresses.
`define BL_HDR_LEN       7'h06
`define BL_MAX_LEN       7'h60
`define BL_EXT_DATA_RAM_BASE     16'hF000
`define BL_EXT_DATA_RAM_TOP      16'hF1FF
`define BL_USER_BASE     16'h0000
`define BL_SYNC_SHIFT    3

`endif

// [pkg/boot_loader_pkg.sv]
/*
 * Types of the serial boot loader.
 * Assumes the constants header is compiled alongside.
 */
`default_nettype none
package boot_loader_pkg;
	typedef enum logic [6:0] {
		ST_IDLE  = 7'b000_0001,
		ST_SYNCW = 7'b000_0010,
		ST_SYNCM = 7'b000_0100,
		ST_RXBLK = 7'b000_1000,
		ST_DRAIN = 7'b001_0000,
		ST_RESP  = 7'b010_0000,
		ST_EXIT  = 7'b100_0000
	} state_t;
endpackage : boot_loader_pkg
`default_nettype wire

// [rtl/boot_loader.sv]
/*
 * Serial boot loader: strap capture, baud measurement on the test byte,
 * block reception with XOR check, mode decode and memory write port.
 * Assumes rx_pin is synchronous to sys_clk and memory accepts one write
 * per cycle without back-pressure.
 */
// Local design decisions: the address map and the strobed register port.
// Function
// - Enter loader when boot-select and test-mode straps both read low at reset.
// - Run synchronization, then header reception, then a response to the host.
// - Mode 00 loads host program into ext_data_ram F000 to F1FF.
// - Mode 01 exits and executes ext_data_ram code at F000.
// - Mode 02 programs host data blocks into Flash.
// - Mode 03 exits and executes the user program at 0000.
// - Mode 04 erases the host-selected Flash sectors.
// - Mode 06 sets or clears Flash protection, then exits.
// - Modes 08 and 09 act like 00 and 01, only over LIN.
// - Mode 0F enters on_chip_debug_support serial mode, only over UART.
// - After load, program or erase, return to wait for the next block.
// - After execute or protection modes leave without a serial session.
// - On some variants load, erase and debug modes refused while protected; the code refuses erase while protected on every variant.
// - A block is type byte, data area, checksum byte in order.
// - Type 00 is header, 01 data, 02 end_block.
// - Header is 8 bytes total with a 6 byte data area.
// - Data and end_block areas at most 96 bytes, length from header.
// - Data blocks only in load and program modes; end_block is last and carries data.
// - XOR of type and data bytes is compared with the checksum.
// - Host sends 80; device measures it, sets baud and answers 55.
// - Answer 55 ok, FF type or sequence, FE checksum, FD protection.
// - Header data area is a mode byte and five parameter bytes.
`timescale 1ns/1ps
`include "boot_loader_map.svh"
`default_nettype none
module boot_loader (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	// Straps and device state
	input  wire logic        boot_select_pin,
	input  wire logic        test_mode_pin,
	input  wire logic        lin_fitted,
	input  wire logic        flash_protected,
	// Serial link
	input  wire logic        rx_pin,
	output logic             tx_pin,
	// Register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// Memory write port
	output logic             mem_we,
	output logic             mem_flash,
	output logic      [15:0] mem_addr,
	output logic      [7:0]  mem_wdata,
	// Mode actions
	output logic             erase_req,
	output logic      [7:0]  erase_sectors,
	output logic             prot_req,
	output logic             prot_enable,
	output logic             exec_req,
	output logic      [15:0] exec_addr,
	output logic             debug_req,
	output logic             loader_active
);
	boot_loader_pkg::state_t st_r;
	logic        straps_done_r, bsl_strap_r, lin_r;
	logic [7:0]  ctrl_r, resp_r, mode_r, btype_r, csum_r;
	logic [15:0] baud_r, meas_r;
	logic [6:0]  idx_r, blk_len_r, didx_r;
	logic        xfer_r, end_seen_r, sent_r;
	logic [7:0]  buf_r [0:95];
	logic [6:0]  exp_len;
	logic        tx_go, prot_block;
	logic [15:0] wr_addr;
	// Receiver and transmitter.
	logic        rx_busy_r, rx_valid_r, tx_busy_r;
	logic [3:0]  rx_bit_r, tx_bit_r;
	logic [15:0] rx_tmr_r, tx_tmr_r;
	logic [7:0]  rx_sh_r, rx_byte_r;
	logic [9:0]  tx_sh_r;

	assign exp_len = (btype_r == `BL_BLK_DATA || btype_r == `BL_BLK_END) ?
		blk_len_r : `BL_HDR_LEN;
	assign tx_go = (st_r == boot_loader_pkg::ST_RESP) && !tx_busy_r && !sent_r;
	assign prot_block = flash_protected && ctrl_r[`BL_CTRL_VAR_BIT];
	// The window test must see the address of this store, not of the previous one.
	assign wr_addr = (didx_r != 7'h00 || mem_we) ? mem_addr + 16'h0001 : mem_addr;

	// Straps are sampled at the first edge after release, never by the reset.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			straps_done_r <= 1'b0;
			bsl_strap_r   <= 1'b0;
			lin_r         <= 1'b0;
		end else if (!straps_done_r) begin
			straps_done_r <= 1'b1;
			bsl_strap_r   <= !boot_select_pin && !test_mode_pin;
			lin_r         <= lin_fitted;
		end
	end

	// Register port: writes steer control, reads show state one cycle later.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_r    <= `BL_CTRL_RESET;
			reg_rdata <= 8'h00;
		end else begin
			if (reg_wr && reg_addr == `BL_OFF_CTRL)
				ctrl_r <= reg_wdata;
			if (reg_rd) begin
				unique case (reg_addr)
					`BL_OFF_CTRL:    reg_rdata <= ctrl_r;
					`BL_OFF_STATE:   reg_rdata <= {1'b0, st_r};
					`BL_OFF_RESP:    reg_rdata <= resp_r;
					`BL_OFF_MODE:    reg_rdata <= mode_r;
					`BL_OFF_BAUD_LO: reg_rdata <= baud_r[7:0];
					`BL_OFF_BAUD_HI: reg_rdata <= baud_r[15:8];
					default:         reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	// Receiver samples mid-bit using the measured bit period.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_busy_r  <= 1'b0;
			rx_valid_r <= 1'b0;
			rx_bit_r   <= 4'h0;
			rx_tmr_r   <= 16'h0000;
			rx_sh_r    <= 8'h00;
			rx_byte_r  <= 8'h00;
		end else begin
			rx_valid_r <= 1'b0;
			if (!rx_busy_r) begin
				if (!rx_pin && st_r == boot_loader_pkg::ST_RXBLK) begin
					rx_busy_r <= 1'b1;
					rx_bit_r  <= 4'h0;
					rx_tmr_r  <= {1'b0, baud_r[15:1]};
				end
			end else if (rx_tmr_r != 16'h0000) begin
				rx_tmr_r <= rx_tmr_r - 16'h0001;
			end else begin
				rx_tmr_r <= baud_r - 16'h0001;
				rx_bit_r <= rx_bit_r + 4'h1;
				if (rx_bit_r == 4'h0 && rx_pin)
					rx_busy_r <= 1'b0;
				else if (rx_bit_r >= 4'h1 && rx_bit_r <= 4'h8)
					rx_sh_r <= {rx_pin, rx_sh_r[7:1]};
				else if (rx_bit_r == 4'h9) begin
					rx_busy_r  <= 1'b0;
					rx_valid_r <= rx_pin;
					rx_byte_r  <= rx_sh_r;
				end
			end
		end
	end

	// Transmitter sends start, eight data bits LSB first, and stop.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_busy_r <= 1'b0;
			tx_bit_r  <= 4'h0;
			tx_tmr_r  <= 16'h0000;
			tx_sh_r   <= 10'h3FF;
			tx_pin    <= 1'b1;
		end else if (!tx_busy_r) begin
			tx_pin <= 1'b1;
			if (tx_go) begin
				tx_busy_r <= 1'b1;
				tx_sh_r   <= {1'b1, resp_r, 1'b0};
				tx_bit_r  <= 4'h0;
				tx_tmr_r  <= 16'h0000;
			end
		end else if (tx_tmr_r != 16'h0000) begin
			tx_tmr_r <= tx_tmr_r - 16'h0001;
		end else if (tx_bit_r == 4'hA) begin
			tx_busy_r <= 1'b0;
		end else begin
			tx_pin   <= tx_sh_r[0];
			tx_sh_r  <= {1'b1, tx_sh_r[9:1]};
			tx_bit_r <= tx_bit_r + 4'h1;
			tx_tmr_r <= baud_r - 16'h0001;
		end
	end

	// Block buffer; contents reach memory only after the checksum matches.
	always_ff @(posedge sys_clk) begin
		if (st_r == boot_loader_pkg::ST_RXBLK && rx_valid_r &&
				idx_r != 7'h00 && idx_r <= exp_len)
			buf_r[idx_r - 7'h01] <= rx_byte_r;
	end

	// Main sequence: synchronize, take blocks, act, answer.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r          <= boot_loader_pkg::ST_IDLE;
			resp_r        <= 8'h00;
			mode_r        <= 8'h00;
			btype_r       <= 8'h00;
			csum_r        <= 8'h00;
			baud_r        <= 16'h0001;
			meas_r        <= 16'h0000;
			idx_r         <= 7'h00;
			didx_r        <= 7'h00;
			blk_len_r     <= 7'h00;
			xfer_r        <= 1'b0;
			end_seen_r    <= 1'b0;
			sent_r        <= 1'b0;
			mem_we        <= 1'b0;
			mem_flash     <= 1'b0;
			mem_addr      <= 16'h0000;
			mem_wdata     <= 8'h00;
			erase_req     <= 1'b0;
			erase_sectors <= 8'h00;
			prot_req      <= 1'b0;
			prot_enable   <= 1'b0;
			exec_req      <= 1'b0;
			exec_addr     <= 16'h0000;
			debug_req     <= 1'b0;
			loader_active <= 1'b0;
		end else begin
			mem_we    <= 1'b0;
			erase_req <= 1'b0;
			prot_req  <= 1'b0;
			exec_req  <= 1'b0;
			debug_req <= 1'b0;
			unique case (st_r)
			boot_loader_pkg::ST_IDLE: begin
				if (straps_done_r && bsl_strap_r && ctrl_r[`BL_CTRL_EN_BIT]) begin
					st_r          <= boot_loader_pkg::ST_SYNCW;
					loader_active <= 1'b1;
				end
			end
			boot_loader_pkg::ST_SYNCW: begin
				if (!rx_pin) begin
					st_r   <= boot_loader_pkg::ST_SYNCM;
					meas_r <= 16'h0001;
				end
			end
			boot_loader_pkg::ST_SYNCM: begin
				// The test byte is low for start plus seven zero bits.
				if (rx_pin) begin
					baud_r <= (meas_r >> `BL_SYNC_SHIFT) == 16'h0000 ? 16'h0001 :
						meas_r >> `BL_SYNC_SHIFT;
					resp_r <= `BL_RSP_OK;
					idx_r  <= 7'h00;
					st_r   <= boot_loader_pkg::ST_RESP;
				end else if (meas_r != 16'hFFFF)
					meas_r <= meas_r + 16'h0001;
			end
			boot_loader_pkg::ST_RXBLK: begin
				if (rx_valid_r) begin
					idx_r <= idx_r + 7'h01;
					if (idx_r == 7'h00) begin
						btype_r <= rx_byte_r;
						csum_r  <= rx_byte_r;
					end else if (idx_r <= exp_len) begin
						csum_r <= csum_r ^ rx_byte_r;
					end else begin
						idx_r <= 7'h00;
						st_r  <= boot_loader_pkg::ST_RESP;
						resp_r <= `BL_RSP_OK;
						if (csum_r != rx_byte_r)
							resp_r <= `BL_RSP_CSUM;
						else if (btype_r == `BL_BLK_HEADER) begin
							mode_r <= buf_r[0];
							if (xfer_r)
								resp_r <= `BL_RSP_TYPE;
							else begin
								unique case (buf_r[0])
								`BL_MODE_XLOAD, `BL_MODE_LXLOAD: begin
									if (buf_r[0] == `BL_MODE_LXLOAD && !lin_r)
										resp_r <= `BL_RSP_TYPE;
									else if (prot_block)
										resp_r <= `BL_RSP_PROT;
									else if (buf_r[1][6:0] == 7'h00 ||
											buf_r[1][6:0] > `BL_MAX_LEN || buf_r[1][7])
										resp_r <= `BL_RSP_TYPE;
									else begin
										xfer_r    <= 1'b1;
										mem_flash <= 1'b0;
										mem_addr  <= `BL_EXT_DATA_RAM_BASE;
										blk_len_r <= buf_r[1][6:0];
									end
								end
								`BL_MODE_FPROG: begin
									if (flash_protected)
										resp_r <= `BL_RSP_PROT;
									else if (buf_r[1][6:0] == 7'h00 ||
											buf_r[1][6:0] > `BL_MAX_LEN || buf_r[1][7])
										resp_r <= `BL_RSP_TYPE;
									else begin
										xfer_r    <= 1'b1;
										mem_flash <= 1'b1;
										mem_addr  <= {buf_r[2], buf_r[3]};
										blk_len_r <= buf_r[1][6:0];
									end
								end
								`BL_MODE_ERASE: begin
									if (flash_protected)
										resp_r <= `BL_RSP_PROT;
									else begin
										erase_req     <= 1'b1;
										erase_sectors <= buf_r[1];
									end
								end
								`BL_MODE_XEXEC, `BL_MODE_LXEXEC, `BL_MODE_UEXEC: begin
									if (buf_r[0] == `BL_MODE_LXEXEC && !lin_r)
										resp_r <= `BL_RSP_TYPE;
									else begin
										exec_req  <= 1'b1;
										exec_addr <= buf_r[0] == `BL_MODE_UEXEC ?
											`BL_USER_BASE : `BL_EXT_DATA_RAM_BASE;
										st_r          <= boot_loader_pkg::ST_EXIT;
										loader_active <= 1'b0;
									end
								end
								`BL_MODE_PROT: begin
									prot_req      <= 1'b1;
									prot_enable   <= buf_r[1][0];
									st_r          <= boot_loader_pkg::ST_EXIT;
									loader_active <= 1'b0;
								end
								`BL_MODE_DEBUG: begin
									if (lin_r)
										resp_r <= `BL_RSP_TYPE;
									else if (prot_block)
										resp_r <= `BL_RSP_PROT;
									else begin
										debug_req     <= 1'b1;
										st_r          <= boot_loader_pkg::ST_EXIT;
										loader_active <= 1'b0;
									end
								end
								default: resp_r <= `BL_RSP_TYPE;
								endcase
							end
						end else if (btype_r == `BL_BLK_DATA || btype_r == `BL_BLK_END) begin
							if (!xfer_r)
								resp_r <= `BL_RSP_TYPE;
							else begin
								end_seen_r <= btype_r == `BL_BLK_END;
								didx_r     <= 7'h00;
								st_r       <= boot_loader_pkg::ST_DRAIN;
							end
						end else
							resp_r <= `BL_RSP_TYPE;
					end
				end
			end
			boot_loader_pkg::ST_DRAIN: begin
				// Stores beyond the top of the ext_data_ram window are dropped.
				mem_we    <= mem_flash ||
					(wr_addr >= `BL_EXT_DATA_RAM_BASE && wr_addr <= `BL_EXT_DATA_RAM_TOP);
				mem_wdata <= buf_r[didx_r];
				mem_addr  <= wr_addr;
				didx_r <= didx_r + 7'h01;
				if (didx_r == blk_len_r - 7'h01) begin
					st_r <= boot_loader_pkg::ST_RESP;
					if (end_seen_r)
						xfer_r <= 1'b0;
				end
			end
			boot_loader_pkg::ST_RESP: begin
				if (mem_we)
					mem_addr <= mem_addr + 16'h0001;
				if (tx_go)
					sent_r <= 1'b1;
				else if (sent_r && !tx_busy_r) begin
					sent_r <= 1'b0;
					st_r   <= boot_loader_pkg::ST_RXBLK;
				end
			end
			boot_loader_pkg::ST_EXIT: st_r <= boot_loader_pkg::ST_EXIT;
			endcase
		end
	end
endmodule : boot_loader
`default_nettype wire

// [bench/boot_loader_checker.sv]
/* Port checker for the boot loader, bound into every boot_loader.
   Assumes straps and lin_fitted stay steady while the loader runs. */
`timescale 1ns/1ps
`default_nettype none
module boot_loader_checker (
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        arst_n,
	// Straps and state
	input wire logic        boot_select_pin,
	input wire logic        test_mode_pin,
	input wire logic        lin_fitted,
	input wire logic        flash_protected,
	// Outputs watched
	input wire logic        tx_pin,
	input wire logic        mem_we,
	input wire logic        mem_flash,
	input wire logic [15:0] mem_addr,
	input wire logic        erase_req,
	input wire logic        exec_req,
	input wire logic [15:0] exec_addr,
	input wire logic        debug_req,
	input wire logic        loader_active
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	a_entry_needs_straps: assert property ($rose(loader_active) |-> !boot_select_pin && !test_mode_pin)
		else $error("loader entered with a strap high");
	a_exec_target: assert property (exec_req |-> exec_addr == 16'hF000 || exec_addr == 16'h0000)
		else $error("execute address wrong");
	a_exec_leaves: assert property (exec_req |-> ##[0:3] !loader_active)
		else $error("loader stayed active after execute");
	a_quiet_when_out: assert property (!loader_active |-> tx_pin)
		else $error("serial line driven outside the loader");
	a_window_only: assert property (mem_we && !mem_flash |-> mem_addr >= 16'hF000 && mem_addr <= 16'hF1FF)
		else $error("data ram write outside window");
	a_addr_steps: assert property (mem_we ##1 mem_we |-> mem_addr == $past(mem_addr) + 16'h0001)
		else $error("write address did not step");
	a_prot_blocks: assert property (erase_req || (mem_we && mem_flash) |-> !flash_protected)
		else $error("flash touched while protected");
	a_debug_uart: assert property (debug_req |-> !lin_fitted)
		else $error("debug entry over the lin link");
	a_erase_stays: assert property (erase_req |=> loader_active [*3])
		else $error("loader left after erase");
	c_exec: cover property (exec_req);
	c_flash: cover property (mem_we && mem_flash);
	c_erase: cover property (erase_req);
	c_debug: cover property (debug_req);
endmodule : boot_loader_checker
bind boot_loader boot_loader_checker u_chk (.sys_clk(sys_clk), .arst_n(arst_n),
	.boot_select_pin(boot_select_pin), .test_mode_pin(test_mode_pin), .lin_fitted(lin_fitted),
	.flash_protected(flash_protected), .tx_pin(tx_pin), .mem_we(mem_we), .mem_flash(mem_flash),
	.mem_addr(mem_addr), .erase_req(erase_req), .exec_req(exec_req), .exec_addr(exec_addr),
	.debug_req(debug_req), .loader_active(loader_active));
`default_nettype wire

// [bench/host_model.sv]
/* Host side of the serial link: 8N1 sender and a receiver that queues bytes.
   Assumes one clock and a bit period given in clock cycles. */
`timescale 1ns/1ps
`default_nettype none
module host_model #(parameter int BIT_CYC = 8) (
	// Clock
	input  wire logic sys_clk,
	// Serial lines
	output logic      host_tx,
	input  wire logic host_rx
);
	logic [7:0] rx_q[$];
	logic [7:0] rx_b;
	initial host_tx = 1'b1;
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			host_tx <= f[i];
			repeat (BIT_CYC) @(posedge sys_clk);
		end
	endtask : send_byte
	// Type byte, data area, then the XOR checksum, optionally spoiled.
	task automatic send_block(input logic [7:0] typ, input logic [7:0] d[$], input logic bad);
		logic [7:0] s;
		s = typ;
		send_byte(typ);
		foreach (d[i]) begin
			send_byte(d[i]);
			s ^= d[i];
		end
		send_byte(s ^ {8{bad}});
	endtask : send_block
	// Samples mid-bit; the device never leaves the line low between frames.
	always begin
		@(negedge host_rx);
		repeat (BIT_CYC + BIT_CYC / 2) @(posedge sys_clk);
		for (int i = 0; i < 8; i++) begin
			rx_b[i] = host_rx;
			repeat (BIT_CYC) @(posedge sys_clk);
		end
		rx_q.push_back(rx_b);
	end
endmodule : host_model
`default_nettype wire

// [bench/test_boot_loader.sv]
/* Self-checking bench for the boot loader with a serial host model.
   Assumes the constants header and the checker are compiled alongside. */
`timescale 1ns/1ps
`include "boot_loader_map.svh"
`default_nettype none
module test_boot_loader;
	localparam int P = 8;
	logic        sys_clk, arst_n, boot_select_pin, test_mode_pin, lin_fitted, flash_protected;
	logic        rx_pin, tx_pin, reg_wr, reg_rd, mem_we, mem_flash, erase_req, prot_req;
	logic        prot_enable, exec_req, debug_req, loader_active, exp_fl;
	logic [3:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, mem_wdata, erase_sectors, rd, m;
	logic [15:0] mem_addr, exec_addr, exp_addr, last_ex;
	logic [7:0]  dq[$], wq[$];
	logic [7:0]  xm[5] = '{`BL_MODE_XEXEC, `BL_MODE_UEXEC, `BL_MODE_PROT, `BL_MODE_DEBUG,
		`BL_MODE_LXEXEC};
	int          fail_count, cmp_count, cyc, seed, n_ex, n_er, n_pr, n_dbg;
	boot_loader u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .boot_select_pin(boot_select_pin),
		.test_mode_pin(test_mode_pin), .lin_fitted(lin_fitted), .flash_protected(flash_protected),
		.rx_pin(rx_pin), .tx_pin(tx_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_we(mem_we),
		.mem_flash(mem_flash), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .erase_req(erase_req),
		.erase_sectors(erase_sectors), .prot_req(prot_req), .prot_enable(prot_enable),
		.exec_req(exec_req), .exec_addr(exec_addr), .debug_req(debug_req),
		.loader_active(loader_active));
	host_model #(.BIT_CYC(P)) u_host (.sys_clk(sys_clk), .host_tx(rx_pin), .host_rx(tx_pin));
	always #10 sys_clk = ~sys_clk;
	task automatic complete_run();
		if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	function automatic logic [15:0] exp_exec(input logic [7:0] md);
		return (md == `BL_MODE_UEXEC) ? `BL_USER_BASE : `BL_EXT_DATA_RAM_BASE;
	endfunction : exp_exec
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 60000) begin
			fail_count++;
			complete_run();
		end
		if (mem_we === 1'b1) begin
			chk("mem_addr", exp_addr, mem_addr);
			chk("mem_flash", exp_fl, mem_flash);
			exp_addr++;
			wq.push_back(mem_wdata);
		end
		if (exec_req === 1'b1) last_ex = exec_addr;
		n_ex += (exec_req === 1'b1);
		n_er += (erase_req === 1'b1);
		n_pr += (prot_req === 1'b1);
		n_dbg += (debug_req === 1'b1);
	end
	task automatic reg_rw(input logic wr, input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= wr;
		reg_rd <= !wr;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1 if (!wr) chk("reg_rdata", d, reg_rdata);
	endtask : reg_rw
	task automatic get(input logic [7:0] e);
		for (int i = 0; i < 40 * P && u_host.rx_q.size() == 0; i++) @(posedge sys_clk);
		rd = (u_host.rx_q.size() > 0) ? u_host.rx_q.pop_front() : 8'hxx;
		chk("response", e, rd);
		repeat (P) @(posedge sys_clk);
	endtask : get
	task automatic start(input logic bs, input logic lin);
		@(posedge sys_clk);
		arst_n <= 1'b0;
		boot_select_pin <= bs;
		lin_fitted <= lin;
		repeat (5) @(posedge sys_clk);
		chk("tx_pin", 1, tx_pin);
		arst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk("loader_active", !bs, loader_active);
		{n_ex, n_er, n_pr, n_dbg} = '0;
		if (!bs) u_host.send_byte(`BL_SYNC_BYTE);
		if (!bs) get(`BL_RSP_OK);
	endtask : start
	task automatic fill(input int n);
		dq.delete();
		repeat (n) dq.push_back(8'($random(seed)));
	endtask : fill
	task automatic hdr(input logic [7:0] md, input logic [7:0] p1, input logic [15:0] fa);
		dq = {md, p1, fa[15:8], fa[7:0], 8'h00, 8'h00};
	endtask : hdr
	task automatic blk(input logic [7:0] typ, input logic bad, input logic [7:0] e, input int nw);
		wq.delete();
		u_host.send_block(typ, dq, bad);
		get(e);
		chk("writes", 16'(nw), 16'(wq.size()));
		for (int i = 0; i < nw && i < wq.size(); i++) chk("mem_wdata", dq[i], wq[i]);
	endtask : blk
	initial begin
		{sys_clk, arst_n, test_mode_pin, lin_fitted, flash_protected, reg_wr, reg_rd} = '0;
		{boot_select_pin, reg_addr, reg_wdata, cyc, fail_count, cmp_count} = '0;
		seed = 21389;
		start(1, 0);
		start(0, 0);
		reg_rw(0, `BL_OFF_BAUD_LO, 8'(P));
		reg_rw(0, 4'hF, 8'h00);
		// With no header yet the block length is zero: type and checksum only.
		fill(0);
		blk(`BL_BLK_DATA, 0, `BL_RSP_TYPE, 0);
		reg_rw(0, `BL_OFF_RESP, `BL_RSP_TYPE);
		fill(6);
		blk(8'h05, 0, `BL_RSP_TYPE, 0);
		hdr(`BL_MODE_XLOAD, 8'h05, 16'h0000);
		blk(`BL_BLK_HEADER, 1, `BL_RSP_CSUM, 0);
		blk(`BL_BLK_HEADER, 0, `BL_RSP_OK, 0);
		{exp_addr, exp_fl} = {`BL_EXT_DATA_RAM_BASE, 1'b0};
		fill(5);
		blk(`BL_BLK_DATA, 1, `BL_RSP_CSUM, 0);
		fill(5);
		blk(`BL_BLK_DATA, 0, `BL_RSP_OK, 5);
		fill(5);
		blk(`BL_BLK_END, 0, `BL_RSP_OK, 5);
		blk(`BL_BLK_DATA, 0, `BL_RSP_TYPE, 0);
		hdr(`BL_MODE_LXLOAD, 8'h05, 16'h0000);
		blk(`BL_BLK_HEADER, 0, `BL_RSP_TYPE, 0);
		reg_rw(0, `BL_OFF_CTRL, `BL_CTRL_RESET);
		reg_rw(1, `BL_OFF_CTRL, 8'h03);
		flash_protected <= 1'b1;
		hdr(`BL_MODE_XLOAD, 8'h05, 16'h0000);
		blk(`BL_BLK_HEADER, 0, `BL_RSP_PROT, 0);
		hdr(`BL_MODE_FPROG, 8'h20, 16'h1000);
		blk(`BL_BLK_HEADER, 0, `BL_RSP_PROT, 0);
		hdr(`BL_MODE_ERASE, 8'h5A, 16'h0000);
		blk(`BL_BLK_HEADER, 0, `BL_RSP_PROT, 0);
		reg_rw(1, `BL_OFF_CTRL, `BL_CTRL_RESET);
		flash_protected <= 1'b0;
		blk(`BL_BLK_HEADER, 0, `BL_RSP_OK, 0);
		chk("erase", 1, n_er);
		chk("erase_sectors", 8'h5A, erase_sectors);
		hdr(`BL_MODE_FPROG, 8'h20, 16'h1000);
		blk(`BL_BLK_HEADER, 0, `BL_RSP_OK, 0);
		{exp_addr, exp_fl} = {16'h1000, 1'b1};
		fill(24);
		repeat (8) dq.push_back(8'h00);
		blk(`BL_BLK_END, 0, `BL_RSP_OK, 32);
		for (int k = 0; k < 5; k++) begin
			m = xm[k];
			start(0, k == 4);
			hdr(m, 8'h01, 16'h0000);
			u_host.send_block(`BL_BLK_HEADER, dq, 1'b0);
			repeat (40 * P) @(posedge sys_clk);
			chk("replies", 0, 16'(u_host.rx_q.size()));
			chk("loader_active", 0, loader_active);
			chk("exec", 16'(m != `BL_MODE_PROT && m != `BL_MODE_DEBUG), 16'(n_ex));
			if (n_ex > 0) chk("exec_addr", exp_exec(m), last_ex);
			chk("prot", 16'(m == `BL_MODE_PROT), 16'(n_pr));
			if (n_pr > 0) chk("prot_enable", 1, prot_enable);
			chk("debug", 16'(m == `BL_MODE_DEBUG), 16'(n_dbg));
		end
		complete_run();
	end
endmodule : test_boot_loader
`default_nettype wire
